/* verilog/pmrs_pkg.sv */
// Constants and types of the power mode and reset sequencer
package pmrs_pkg;

  // ----------------------------------------------------------------
  // Domain modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PMRS_DOM_ACTIVE = 2'h0,
    PMRS_DOM_HALT   = 2'h1,
    PMRS_DOM_OFF    = 2'h3
  } pmrs_dom_t;

  // ----------------------------------------------------------------
  // System modes, Gray along run -> stop -> standby
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PMRS_SYS_RUN     = 2'h0,
    PMRS_SYS_STOP    = 2'h1,
    PMRS_SYS_STANDBY = 2'h3,
    PMRS_SYS_WAKE    = 2'h2
  } pmrs_sys_t;

  // ----------------------------------------------------------------
  // Clock sources and reset constants
  // ----------------------------------------------------------------
  localparam logic [1:0] PMRS_CLK_FAST_OSC  = 2'h0;
  localparam int         PMRS_NUM_SRC       = 8;
  localparam int         PMRS_RST_HOLD_NS   = 200;
  localparam int         PMRS_CLK_PERIOD_NS = 25;
  localparam logic [3:0] PMRS_RST_HOLD_CYC  =
    4'((PMRS_RST_HOLD_NS + PMRS_CLK_PERIOD_NS - 1) / PMRS_CLK_PERIOD_NS);
  localparam logic [1:0] PMRS_BOR_LVL_RESET = 2'h0;

  // Reset cause bit positions
  localparam int PMRS_SRC_POR  = 0;
  localparam int PMRS_SRC_BOR  = 1;
  localparam int PMRS_SRC_PIN  = 2;
  localparam int PMRS_SRC_WWDG = 3;
  localparam int PMRS_SRC_IWDG = 4;
  localparam int PMRS_SRC_SW   = 5;
  localparam int PMRS_SRC_SEC  = 6;
  localparam int PMRS_SRC_STBY = 7;

endpackage

/* verilog/pmrs_top.sv */
// Power mode tracker and system reset generator
`timescale 1ns/1ps
`default_nettype none
module pmrs_top (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [1:0] wait_for_interrupt_instr_i,
  input  wire logic [1:0] wait_for_event_instr_i,
  input  wire logic [1:0] isr_return_i,
  input  wire logic [1:0] sleep_on_exit_flag_i,
  input  wire logic [1:0] cpu_wake_i,
  input  wire logic [1:0] subsys_lp_i,
  input  wire logic [2:0] periph_lp_i,
  input  wire logic [2:0] dom_off_req_i,
  input  wire logic       sys_standby_req_i,
  input  wire logic       wakeup_pending_i,
  input  wire logic       supply_low_i,
  input  wire logic [2:0] supply_level_i,
  input  wire logic [1:0] bor_level_sel_i,
  input  wire logic       external_reset_pin_b_i,
  input  wire logic       wwdg_rst_i,
  input  wire logic       iwdg_rst_i,
  input  wire logic       sw_rst_i,
  input  wire logic       lp_sec_rst_i,
  input  wire logic [1:0] clk_sel_i,
  input  wire logic       clk_sel_we_i,
  output logic [1:0]      cpu_clock_halt_state_o,
  output logic [1:0]      cpu_subsystem_halt_state_o,
  output logic [1:0]      high_perf_domain_mode_o,
  output logic [1:0]      peripheral_domain_mode_o,
  output logic [1:0]      system_control_domain_mode_o,
  output logic [1:0]      sys_mode_o,
  output logic            sys_rst_b_o,
  output logic            por_rst_b_o,
  output logic [7:0]      rst_cause_o,
  output logic [1:0]      clk_src_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]          pin_s1;
    logic [1:0]          pin_s2;
    logic [3:0]          lvl_s1;
    logic [3:0]          lvl_s2;
    logic [1:0]          cpu_halt;
    logic [1:0]          sub_halt;
    pmrs_pkg::pmrs_dom_t d1;
    pmrs_pkg::pmrs_dom_t d2;
    pmrs_pkg::pmrs_dom_t d3;
    pmrs_pkg::pmrs_sys_t sys;
    logic                stby_exit;
    logic [3:0]          hold;
    logic [7:0]          cause;
    logic [1:0]          clk;
    logic [1:0]          bor_lvl;
    logic                bor_ld;
  } pmrs_st_t;

  pmrs_st_t st_q;
  pmrs_st_t st_d;

  logic       por_req;
  logic       bor_req;
  logic [7:0] src;
  logic [2:0] dom_lp;
  logic [2:0] bor_thr;

  // Domain lowers only if all its parts sleep; else it keeps its mode
  function automatic pmrs_pkg::pmrs_dom_t pmrs_dom_next(input pmrs_pkg::pmrs_dom_t cur,
                                                         input logic all_lp,
                                                         input logic want_off);
    pmrs_pkg::pmrs_dom_t n;
    n = cur;
    if (all_lp) begin
      n = want_off ? pmrs_pkg::PMRS_DOM_OFF : pmrs_pkg::PMRS_DOM_HALT;
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // Combinational next state
  // ----------------------------------------------------------------
  assign por_req = st_q.lvl_s2[3];
  // Threshold levels 0..2 map to three supply codes; compare synced level
  assign bor_thr = 3'(st_q.bor_lvl) + 3'h2;
  assign bor_req = (st_q.lvl_s2[2:0] < bor_thr);

  always_comb begin
    st_d        = st_q;
    st_d.pin_s1 = {external_reset_pin_b_i, supply_low_i};
    st_d.pin_s2 = st_q.pin_s1;
    st_d.lvl_s1 = {st_q.pin_s2[0], supply_level_i};
    st_d.lvl_s2 = st_q.lvl_s1;
    // Option level latched once after power-on, kept across system reset
    st_d.bor_ld = 1'b1;
    if (!st_q.bor_ld) begin
      st_d.bor_lvl = (bor_level_sel_i > 2'h2) ? 2'h2 : bor_level_sel_i;
    end

    src                          = '0;
    src[pmrs_pkg::PMRS_SRC_POR]  = por_req;
    src[pmrs_pkg::PMRS_SRC_BOR]  = bor_req & st_q.bor_ld;
    src[pmrs_pkg::PMRS_SRC_PIN]  = ~st_q.pin_s2[1];
    src[pmrs_pkg::PMRS_SRC_WWDG] = wwdg_rst_i;
    src[pmrs_pkg::PMRS_SRC_IWDG] = iwdg_rst_i;
    src[pmrs_pkg::PMRS_SRC_SW]   = sw_rst_i;
    src[pmrs_pkg::PMRS_SRC_SEC]  = lp_sec_rst_i;
    src[pmrs_pkg::PMRS_SRC_STBY] = st_q.stby_exit;

    // CPU level halt per core
    for (int i = 0; i < 2; i++) begin
      if (cpu_wake_i[i]) begin
        st_d.cpu_halt[i] = 1'b0;
        st_d.sub_halt[i] = 1'b0;
      end else if (wait_for_interrupt_instr_i[i] | wait_for_event_instr_i[i] |
                   (isr_return_i[i] & sleep_on_exit_flag_i[i])) begin
        st_d.cpu_halt[i] = 1'b1;
        st_d.sub_halt[i] = subsys_lp_i[i];
      end
    end

    dom_lp[0] = st_q.cpu_halt[0] & st_q.sub_halt[0] & periph_lp_i[0];
    dom_lp[1] = st_q.cpu_halt[1] & st_q.sub_halt[1] & periph_lp_i[1];
    dom_lp[2] = periph_lp_i[2];
    st_d.stby_exit = 1'b0;

    case (st_q.sys)
      pmrs_pkg::PMRS_SYS_RUN: begin
        st_d.d1 = pmrs_dom_next(st_q.d1, dom_lp[0], dom_off_req_i[0]);
        st_d.d2 = pmrs_dom_next(st_q.d2, dom_lp[1], dom_off_req_i[1]);
        st_d.d3 = pmrs_pkg::PMRS_DOM_ACTIVE;
        if (!wakeup_pending_i && dom_lp[2] &&
            st_q.d1 != pmrs_pkg::PMRS_DOM_ACTIVE &&
            st_q.d2 != pmrs_pkg::PMRS_DOM_ACTIVE) begin
          if (sys_standby_req_i && st_q.d1 == pmrs_pkg::PMRS_DOM_OFF &&
              st_q.d2 == pmrs_pkg::PMRS_DOM_OFF) begin
            st_d.sys = pmrs_pkg::PMRS_SYS_STANDBY;
            st_d.d3  = pmrs_pkg::PMRS_DOM_OFF;
          end else begin
            st_d.sys = pmrs_pkg::PMRS_SYS_STOP;
            st_d.d3  = pmrs_pkg::PMRS_DOM_HALT;
          end
        end
      end
      pmrs_pkg::PMRS_SYS_STOP: begin
        if (wakeup_pending_i) begin
          // Control domain first; the others follow one cycle later
          st_d.sys = pmrs_pkg::PMRS_SYS_WAKE;
          st_d.d3  = pmrs_pkg::PMRS_DOM_ACTIVE;
        end
      end
      pmrs_pkg::PMRS_SYS_WAKE: begin
        st_d.sys = pmrs_pkg::PMRS_SYS_RUN;
        st_d.d1  = pmrs_pkg::PMRS_DOM_ACTIVE;
        st_d.d2  = pmrs_pkg::PMRS_DOM_ACTIVE;
      end
      pmrs_pkg::PMRS_SYS_STANDBY: begin
        if (wakeup_pending_i) begin
          st_d.stby_exit = 1'b1;
        end
      end
      default: st_d.sys = pmrs_pkg::PMRS_SYS_RUN;
    endcase

    // Clock source select applies only outside reset
    if (clk_sel_we_i) begin
      st_d.clk = clk_sel_i;
    end

    // System reset: cause sticky, hold stretch, partial reinit
    if (|src) begin
      st_d.cause = st_q.cause | src;
      st_d.hold  = pmrs_pkg::PMRS_RST_HOLD_CYC;
    end else if (st_q.hold != 4'h0) begin
      st_d.hold = st_q.hold - 4'h1;
    end
    if (|src || st_q.hold != 4'h0) begin
      st_d.cpu_halt = '0;
      st_d.sub_halt = '0;
      st_d.d1       = pmrs_pkg::PMRS_DOM_ACTIVE;
      st_d.d2       = pmrs_pkg::PMRS_DOM_ACTIVE;
      st_d.d3       = pmrs_pkg::PMRS_DOM_ACTIVE;
      st_d.sys      = pmrs_pkg::PMRS_SYS_RUN;
      st_d.clk      = pmrs_pkg::PMRS_CLK_FAST_OSC;
    end
  end

  // ----------------------------------------------------------------
  // Registers: power-on reset clears all state but presets synchronisers to idle levels and hold to PMRS_RST_HOLD_CYC
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q         <= '0;
      st_q.pin_s1  <= 2'h2;
      st_q.pin_s2  <= 2'h2;
      st_q.lvl_s1  <= 4'h7;
      st_q.lvl_s2  <= 4'h7;
      st_q.hold    <= pmrs_pkg::PMRS_RST_HOLD_CYC;
      st_q.clk     <= pmrs_pkg::PMRS_CLK_FAST_OSC;
      st_q.bor_lvl <= pmrs_pkg::PMRS_BOR_LVL_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cpu_clock_halt_state_o       = st_q.cpu_halt;
  assign cpu_subsystem_halt_state_o   = st_q.sub_halt;
  assign high_perf_domain_mode_o      = st_q.d1;
  assign peripheral_domain_mode_o     = st_q.d2;
  assign system_control_domain_mode_o = st_q.d3;
  assign sys_mode_o                   = st_q.sys;
  assign sys_rst_b_o                  = (st_q.hold == 4'h0);
  assign por_rst_b_o                  = st_q.bor_ld & ~st_q.lvl_s2[3];
  assign rst_cause_o                  = st_q.cause;
  assign clk_src_o                    = st_q.clk;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_run_ctrl_active;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      st_q.sys == pmrs_pkg::PMRS_SYS_RUN |-> st_q.d3 == pmrs_pkg::PMRS_DOM_ACTIVE;
  endproperty
  a_run_ctrl_active: assert property (p_run_ctrl_active) else $error("control domain not active in run");

  property p_stby_all_off;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      st_q.sys == pmrs_pkg::PMRS_SYS_STANDBY |-> st_q.d1 == pmrs_pkg::PMRS_DOM_OFF &&
        st_q.d2 == pmrs_pkg::PMRS_DOM_OFF && st_q.d3 == pmrs_pkg::PMRS_DOM_OFF;
  endproperty
  a_stby_all_off: assert property (p_stby_all_off) else $error("standby with a domain on");

  property p_low_needs_idle;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      $rose(st_q.sys != pmrs_pkg::PMRS_SYS_RUN) && st_q.sys != pmrs_pkg::PMRS_SYS_WAKE
        |-> !$past(wakeup_pending_i);
  endproperty
  a_low_needs_idle: assert property (p_low_needs_idle) else $error("low mode entered with wakeup pending");

  sequence s_wake_ctrl;
    st_q.sys == pmrs_pkg::PMRS_SYS_WAKE && st_q.d3 == pmrs_pkg::PMRS_DOM_ACTIVE;
  endsequence
  property p_wake_order;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      st_q.sys == pmrs_pkg::PMRS_SYS_STOP && wakeup_pending_i && (src == '0) && st_q.hold == 4'h0
        |=> s_wake_ctrl ##1 st_q.sys == pmrs_pkg::PMRS_SYS_RUN;
  endproperty
  a_wake_order: assert property (p_wake_order) else $error("wake order broken");

  property p_src_resets;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      |src |=> !sys_rst_b_o [*8];
  endproperty
  a_src_resets: assert property (p_src_resets) else $error("source did not hold system reset");

  property p_reset_clk;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      !sys_rst_b_o |-> clk_src_o == pmrs_pkg::PMRS_CLK_FAST_OSC;
  endproperty
  a_reset_clk: assert property (p_reset_clk) else $error("clock not fast oscillator in reset");

  property p_supply_hold;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      st_q.lvl_s2[3] |=> !sys_rst_b_o;
  endproperty
  a_supply_hold: assert property (p_supply_hold) else $error("reset released under low supply");

  property p_dom_keep;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      st_q.sys == pmrs_pkg::PMRS_SYS_RUN && !dom_lp[0] && (src == '0) && st_q.hold == 4'h0
        |=> $stable(st_q.d1);
  endproperty
  a_dom_keep: assert property (p_dom_keep) else $error("domain lowered while awake");

  property p_dom_lower_idle;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      $changed(st_q.d1) && st_q.d1 != pmrs_pkg::PMRS_DOM_ACTIVE
        |-> $past(periph_lp_i[0]) && $past(st_q.cpu_halt[0]) && $past(st_q.sub_halt[0]);
  endproperty
  a_dom_lower_idle: assert property (p_dom_lower_idle) else $error("domain lowered with a part awake");

  property p_halt_entry;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      !cpu_wake_i[0] && (wait_for_interrupt_instr_i[0] || wait_for_event_instr_i[0]) &&
        (src == '0) && st_q.hold == 4'h0 |=> cpu_clock_halt_state_o[0];
  endproperty
  a_halt_entry: assert property (p_halt_entry) else $error("core did not halt on wait instruction");

  property p_stop_modes;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      st_q.sys == pmrs_pkg::PMRS_SYS_STOP |-> st_q.d1 != pmrs_pkg::PMRS_DOM_ACTIVE &&
        st_q.d2 != pmrs_pkg::PMRS_DOM_ACTIVE && st_q.d3 == pmrs_pkg::PMRS_DOM_HALT;
  endproperty
  a_stop_modes: assert property (p_stop_modes) else $error("stop with a domain in wrong mode");

  property p_bor_low;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      st_q.bor_ld && (st_q.lvl_s2[2:0] < 3'h2) |=> !sys_rst_b_o && rst_cause_o[pmrs_pkg::PMRS_SRC_BOR];
  endproperty
  a_bor_low: assert property (p_bor_low) else $error("supply under lowest level without reset");

  // Causes survive system reset; only power-on reset clears them
  property p_cause_kept;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      ($past(rst_cause_o) & ~rst_cause_o) == 8'h00;
  endproperty
  a_cause_kept: assert property (p_cause_kept) else $error("reset cause lost by system reset");

endmodule
`default_nettype wire

/* testbench/pmrs_far_model.sv */
// Far-side model: both cores, domain peripherals and the wakeup event controller
`timescale 1ns/1ps
`default_nettype none
module pmrs_far_model (
  input  wire logic       ref_clk_i,
  output logic [1:0]      wfi_o,
  output logic [1:0]      wfe_o,
  output logic [1:0]      isr_ret_o,
  output logic [1:0]      soe_o,
  output logic [1:0]      wake_o,
  output logic [1:0]      subsys_lp_o,
  output logic [2:0]      periph_lp_o,
  output logic [2:0]      dom_off_o,
  output logic            stby_o,
  output logic            pend_o
);
  initial begin
    {wfi_o, wfe_o, isr_ret_o, soe_o, wake_o, subsys_lp_o} = 12'h000;
    {periph_lp_o, dom_off_o, stby_o, pend_o} = 8'h00;
  end
  // Instructions and wakes last one cycle; kind 0 wfi, 1 wfe, 2 isr return, 3 wake
  task automatic pulse(input int kind, input logic [1:0] m);
    @(posedge ref_clk_i) #1;
    case (kind)
      0: wfi_o = m;
      1: wfe_o = m;
      2: isr_ret_o = m;
      default: wake_o = m;
    endcase
    @(posedge ref_clk_i) #1;
    {wfi_o, wfe_o, isr_ret_o, wake_o} = 8'h00;
  endtask
  // Idle levels of subsystems and peripherals; a pending wakeup is held as a level
  task automatic levels(input logic [1:0] sub, input logic [2:0] per, input logic [2:0] off,
                        input logic sb, input logic pd, input logic [1:0] so);
    @(posedge ref_clk_i) #1;
    {subsys_lp_o, periph_lp_o, dom_off_o, stby_o, pend_o, soe_o} = {sub, per, off, sb, pd, so};
  endtask
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Self-checking testbench of the power mode and reset sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       ref_clk_i = 1'b0;
  logic       rst_b_i = 1'b0;
  logic       supply_low_i = 1'b0;
  logic [2:0] supply_level_i = 3'h7;
  logic [1:0] bor_level_sel_i = 2'h0;
  logic       pin_b = 1'b1;
  logic [3:0] req = 4'h0;
  logic [1:0] clk_sel = 2'h0;
  logic       clk_we = 1'b0;
  logic [1:0] wait_for_interrupt_instr, wait_for_event_instr, isr_ret, soe, wake, sub_lp, cpu_h, sub_h, m1, m2, m3, sm, clk_src;
  logic [2:0] per_lp, off;
  logic       stby, pend, srst_b, por_b;
  logic [7:0] cause;
  int         n_errors = 0;
  int         n_tests = 0;

  always #12.5 ref_clk_i = ~ref_clk_i;

  pmrs_far_model far_u (.ref_clk_i, .wfi_o(wait_for_interrupt_instr), .wfe_o(wait_for_event_instr), .isr_ret_o(isr_ret), .soe_o(soe),
    .wake_o(wake), .subsys_lp_o(sub_lp), .periph_lp_o(per_lp), .dom_off_o(off), .stby_o(stby),
    .pend_o(pend));
  pmrs_top dut_u (.ref_clk_i, .rst_b_i, .wait_for_interrupt_instr_i(wait_for_interrupt_instr), .wait_for_event_instr_i(wait_for_event_instr),
    .isr_return_i(isr_ret), .sleep_on_exit_flag_i(soe), .cpu_wake_i(wake), .subsys_lp_i(sub_lp),
    .periph_lp_i(per_lp), .dom_off_req_i(off), .sys_standby_req_i(stby), .wakeup_pending_i(pend),
    .supply_low_i, .supply_level_i, .bor_level_sel_i, .external_reset_pin_b_i(pin_b),
    .wwdg_rst_i(req[0]), .iwdg_rst_i(req[1]), .sw_rst_i(req[2]), .lp_sec_rst_i(req[3]),
    .clk_sel_i(clk_sel), .clk_sel_we_i(clk_we), .cpu_clock_halt_state_o(cpu_h),
    .cpu_subsystem_halt_state_o(sub_h), .high_perf_domain_mode_o(m1), .peripheral_domain_mode_o(m2),
    .system_control_domain_mode_o(m3), .sys_mode_o(sm), .sys_rst_b_o(srst_b), .por_rst_b_o(por_b),
    .rst_cause_o(cause), .clk_src_o(clk_src));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Every step lands 1 ns after an edge, so flops have settled and drives stay off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wait_rst(input logic v, input int lim, input string what);
    int i;
    i = 0;
    while (srst_b !== v && i < lim) begin
      i++;
      cyc(1);
    end
    chk(what, {7'h0, v}, {7'h0, srst_b});
  endtask
  task automatic wait_sys(input logic [1:0] v, input int lim);
    int i;
    i = 0;
    while (sm !== v && i < lim) begin
      i++;
      cyc(1);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_sync_src(input int b);
    int n;
    n = 0;
    req = 4'h1 << (b - 3);
    cyc(1);
    req = 4'h0;
    while (srst_b === 1'b0 && n < 40) begin
      n++;
      cyc(1);
    end
    chk("hold", 8'h08, 8'(n));
    chk("cause", 8'h01, {7'h0, cause[b]});
    cyc(2);
  endtask
  // Asynchronous sources pass a synchroniser, so only the level is judged, not the edge
  task automatic t_async(input int k);
    if (k == 0) pin_b = 1'b0;
    if (k == 1) supply_level_i = 3'h1;
    if (k == 2) supply_low_i = 1'b1;
    cyc(5);
    chk("async", 8'h00, {7'h0, srst_b});
    if (k == 2) chk("por", 8'h00, {7'h0, por_b});
    else chk("cause", 8'h01, {7'h0, cause[2 - k]});
    pin_b = 1'b1;
    supply_level_i = 3'h7;
    supply_low_i = 1'b0;
    wait_rst(1'b1, 40, "async_rel");
  endtask
  task automatic t_clk();
    clk_sel = 2'h2;
    clk_we = 1'b1;
    cyc(1);
    clk_we = 1'b0;
    cyc(1);
    chk("clk_sel", 8'h02, {6'h0, clk_src});
    req = 4'h4;
    cyc(1);
    req = 4'h0;
    clk_we = 1'b1;
    cyc(1);
    clk_we = 1'b0;
    cyc(1);
    chk("clk_rst", 8'h00, {6'h0, clk_src});
    wait_rst(1'b1, 20, "clk_rel");
  endtask
  task automatic t_halt();
    far_u.levels(2'h0, 3'h0, 3'h0, 1'b0, 1'b0, 2'h1);
    far_u.pulse(2, 2'h3);
    cyc(1);
    chk("soe_halt", 8'h01, {6'h0, cpu_h});
    far_u.pulse(3, 2'h3);
    far_u.pulse(1, 2'h2);
    cyc(1);
    chk("wfe_halt", 8'h02, {6'h0, cpu_h});
    chk("dom_hold", 8'h00, {m1, m2, m3, sm});
    far_u.pulse(3, 2'h3);
    cyc(1);
    chk("woken", 8'h00, {6'h0, cpu_h});
  endtask
  task automatic t_stop();
    far_u.levels(2'h3, 3'h6, 3'h0, 1'b0, 1'b1, 2'h0);
    far_u.pulse(0, 2'h3);
    cyc(4);
    chk("cpu_sub", 8'h0f, {4'h0, cpu_h, sub_h});
    chk("partial", 8'h10, {m1, m2, m3, sm});
    far_u.levels(2'h3, 3'h7, 3'h0, 1'b0, 1'b1, 2'h0);
    cyc(4);
    chk("pending", 8'h50, {m1, m2, m3, sm});
    far_u.levels(2'h3, 3'h7, 3'h0, 1'b0, 1'b0, 2'h0);
    wait_sys(2'h1, 10);
    chk("stop", 8'h55, {m1, m2, m3, sm});
    far_u.levels(2'h3, 3'h7, 3'h0, 1'b0, 1'b1, 2'h0);
    cyc(1);
    chk("wake_d3", 8'h52, {m1, m2, m3, sm});
    cyc(1);
    chk("run", 8'h00, {m1, m2, m3, sm});
    far_u.pulse(3, 2'h3);
    far_u.levels(2'h0, 3'h0, 3'h0, 1'b0, 1'b0, 2'h0);
    cyc(1);
    chk("cpu_run", 8'h00, {6'h0, cpu_h});
    // Cores still halted after wake let the domains drop again; awake cores keep them there
    chk("kept", 8'h50, {m1, m2, m3, sm});
    req = 4'h4;
    cyc(1);
    req = 4'h0;
    wait_rst(1'b1, 20, "stop_rst");
    chk("reinit", 8'h00, {m1, m2, m3, sm});
  endtask
  task automatic t_stby();
    far_u.levels(2'h3, 3'h7, 3'h3, 1'b1, 1'b0, 2'h0);
    far_u.pulse(0, 2'h3);
    wait_sys(2'h3, 12);
    chk("standby", 8'hff, {m1, m2, m3, sm});
    far_u.levels(2'h0, 3'h0, 3'h0, 1'b0, 1'b1, 2'h0);
    wait_rst(1'b0, 4, "stby_exit");
    chk("cause", 8'h01, {7'h0, cause[7]});
    far_u.levels(2'h0, 3'h0, 3'h0, 1'b0, 1'b0, 2'h0);
    wait_rst(1'b1, 40, "stby_rel");
    chk("after", 8'h00, {cpu_h, sub_h, m1, sm});
  endtask
  task automatic t_por();
    rst_b_i = 1'b0;
    bor_level_sel_i = 2'h3;
    cyc(2);
    chk("por_hold", 8'h00, {7'h0, srst_b});
    rst_b_i = 1'b1;
    wait_rst(1'b1, 40, "por_rel");
    chk("cause_clr", 8'h00, cause);
    // Option 3 clamps to the top level; later option changes are ignored
    bor_level_sel_i = 2'h0;
    supply_level_i = 3'h4;
    cyc(6);
    chk("bor_top_ok", 8'h01, {7'h0, srst_b});
    supply_level_i = 3'h3;
    cyc(5);
    chk("bor_top", 8'h00, {7'h0, srst_b});
    chk("bor_cause", 8'h01, {7'h0, cause[1]});
    supply_level_i = 3'h7;
    wait_rst(1'b1, 40, "bor_rel");
  endtask
  task automatic close_out();
    $display("Tests %0d, errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    cyc(12);
    rst_b_i = 1'b1;
    wait_rst(1'b1, 40, "boot");
    chk("clk_src", 8'h00, {6'h0, clk_src});
    chk("modes", 8'h00, {m1, m2, m3, sm});
    chk("por_b", 8'h01, {7'h0, por_b});
    for (int b = 3; b <= 6; b++) t_sync_src(b);
    for (int k = 0; k < 3; k++) t_async(k);
    // Code 2 sits exactly on the lowest threshold and must not trip
    supply_level_i = 3'h2;
    cyc(6);
    chk("bor_edge", 8'h01, {7'h0, srst_b});
    supply_level_i = 3'h7;
    t_clk();
    t_halt();
    t_stop();
    t_stby();
    t_por();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_errors++;
    close_out();
  end
endmodule
`default_nettype wire
